//--- rtl/dlc_map.svh
/*
  Register offsets, field positions, reset values and timing counts of the
  driver limit and control register bank. Included by the core only.
*/
`ifndef DLC_MAP_SVH
`define DLC_MAP_SVH

`define DLC_STATUS_OFF 8'h02
`define DLC_LIMIT_OFF 8'h05
`define DLC_CTRL_OFF 8'h06
`define DLC_LIMIT_RST 8'h00
`define DLC_CTRL_RST 8'h00

// Limit register fields.
`define DLC_LIM_LEVEL_HI 7
`define DLC_LIM_LEVEL_LO 6
`define DLC_LIM_OFF_BIT 5
`define DLC_LIM_TAR_HI 2
`define DLC_LIM_TAR_LO 1
`define DLC_LIM_RETRY_BIT 0

// Control register fields.
`define DLC_CTL_REG_OFF 7
`define DLC_CTL_WAKE_OFF 6
`define DLC_CTL_AUX_OFF 5
`define DLC_CTL_AUX_FILT 4
`define DLC_CTL_RX_OFF 3
`define DLC_CTL_RX_FILT 2
`define DLC_CTL_AUX_Q 1
`define DLC_CTL_COMM_Q 0

// Timing: clock period, glitch filter, millisecond tick and off-times.
`define DLC_CLK_NS 50
`define DLC_FILT_NS 1000
`define DLC_TICK_NS 1000000
`define DLC_OFF_MS_0 10'd50
`define DLC_OFF_MS_1 10'd100
`define DLC_OFF_MS_2 10'd200
`define DLC_OFF_MS_3 10'd500

`endif

//--- rtl/dlc_pkg.sv
/*
  Types of the driver limit and control register bank.
  Uses no macros from dlc_map.svh and does not include it.
*/
package dlc_pkg;
  // One register access from the serial front end, valid for one cycle.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } dlc_req_t;

  // Whole state of the core.
  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] lim;
    logic [1:0] flt_s1;
    logic [1:0] flt_s2;
    logic [1:0] line_s1;
    logic [1:0] line_s2;
    logic [4:0] fcnt;
    logic cfilt;
    logic [1:0] off;
    logic [1:0][9:0] ocnt;
    logic [14:0] tick;
    logic tick_p;
    logic [7:0] rdata;
  } dlc_state_t;
endpackage

//--- rtl/dlc_core.sv
/*
  Driver limit and control register bank of a dual-channel line transceiver:
  current-limit setup, fault off-time with auto-retry, receiver and regulator
  controls. Channel 0 is the communication line, channel 1 the auxiliary line.
  Assumes a serial front end (SPI or I2C) that presents one-cycle register
  accesses on clk_i, and analog fault and line comparators that are asynchronous.
*/
`timescale 1ns/1ps
`include "dlc_map.svh"

module dlc_core
  import dlc_pkg::*;
#(
  parameter int TICK_CYCLES = `DLC_TICK_NS / `DLC_CLK_NS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire dlc_req_t req_i,
  output logic [7:0] rdata_o,
  input wire logic comm_fault_i,
  input wire logic aux_fault_i,
  input wire logic comm_line_i,
  input wire logic aux_line_i,
  output logic [1:0] limit_level_sel_o,
  output logic limit_active_o,
  output logic comm_drive_level_o,
  output logic comm_drive_en_o,
  output logic aux_drive_level_o,
  output logic aux_drive_en_o,
  output logic low_regulator_off_o,
  output logic wakeup_detect_off_o,
  output logic aux_glitch_filter_en_o,
  output logic receive_out_o,
  output logic receive_out_oe_o,
  output logic aux_logic_out_o
);

  // Filter length is rounded up, so a glitch just under 1us never passes.
  localparam int FILT_CYC = (`DLC_FILT_NS + `DLC_CLK_NS - 1) / `DLC_CLK_NS;

  dlc_state_t s_r;
  dlc_state_t s_nxt;
  logic [9:0] off_ms;
  logic sw_write;
  logic comm_level_status;
  logic aux_level_status;

  // Selected off-time in milliseconds.
  always_comb begin
    case (s_r.lim[`DLC_LIM_TAR_HI:`DLC_LIM_TAR_LO])
      2'h0: off_ms = `DLC_OFF_MS_0;
      2'h1: off_ms = `DLC_OFF_MS_1;
      2'h2: off_ms = `DLC_OFF_MS_2;
      2'h3: off_ms = `DLC_OFF_MS_3;
      default: off_ms = `DLC_OFF_MS_0;
    endcase
  end

  // Line status is forced to zero while the matching receiver is disabled.
  assign comm_level_status = s_r.cfilt & ~s_r.ctl[`DLC_CTL_RX_OFF];
  assign aux_level_status = s_r.line_s2[1] & ~s_r.ctl[`DLC_CTL_AUX_OFF];
  // Any write to either configuration register counts as software reconfiguring a driver.
  assign sw_write = req_i.wr &&
                    (req_i.addr == `DLC_LIMIT_OFF || req_i.addr == `DLC_CTRL_OFF);

  // Next-state logic for registers, synchronisers, filter and fault timers.
  always_comb begin
    s_nxt = s_r;
    // Two flip-flops on every pin input keep metastability away from the fault and filter logic.
    s_nxt.flt_s1 = {aux_fault_i, comm_fault_i};
    s_nxt.flt_s2 = s_r.flt_s1;
    s_nxt.line_s1 = {aux_line_i, comm_line_i};
    s_nxt.line_s2 = s_r.line_s1;
    // Free-running millisecond tick keeps the off-time counters narrow.
    // The tick is not aligned to the fault, so an off-time lasts N to N+1 ms.
    if (s_r.tick == 15'(TICK_CYCLES - 1)) begin
      s_nxt.tick = 15'h0000;
      s_nxt.tick_p = 1'b1;
    end else begin
      s_nxt.tick = s_r.tick + 15'h0001;
      s_nxt.tick_p = 1'b0;
    end
    if (req_i.wr && req_i.addr == `DLC_LIMIT_OFF) begin
      s_nxt.lim = req_i.wdata;
    end
    if (req_i.wr && req_i.addr == `DLC_CTRL_OFF) begin
      s_nxt.ctl = req_i.wdata;
    end
    // Receive glitch filter: a change passes only after standing FILT_CYC cycles.
    // The filter delays every real edge by FILT_CYC cycles as well.
    if (!s_r.ctl[`DLC_CTL_RX_FILT] || s_r.line_s2[0] == s_r.cfilt) begin
      s_nxt.cfilt = s_r.line_s2[0];
      s_nxt.fcnt = 5'h00;
    end else if (s_r.fcnt == 5'(FILT_CYC - 1)) begin
      s_nxt.cfilt = s_r.line_s2[0];
      s_nxt.fcnt = 5'h00;
    end else begin
      s_nxt.fcnt = s_r.fcnt + 5'h01;
    end
    // Per-driver fault handling; a fault in a write cycle still wins.
    for (int c = 0; c < 2; c++) begin
      if (s_r.flt_s2[c] && !s_r.off[c]) begin
        s_nxt.off[c] = 1'b1;
        s_nxt.ocnt[c] = off_ms;
      end else if (s_r.off[c] && s_r.lim[`DLC_LIM_RETRY_BIT]) begin
        if (s_r.tick_p) begin
          if (s_r.ocnt[c] == 10'h000) begin
            // A fault still present at release keeps the driver off for another full period.
            s_nxt.off[c] = s_r.flt_s2[c];
            s_nxt.ocnt[c] = off_ms;
          end else begin
            s_nxt.ocnt[c] = s_r.ocnt[c] - 10'h001;
          end
        end
      end else if (s_r.off[c] && sw_write && !s_r.flt_s2[c]) begin
        s_nxt.off[c] = 1'b0;
      end
    end
    // Read data is captured one cycle after the request; holes read zero.
    // A status read shows the fault and line state of the cycle in which it is taken.
    if (req_i.rd) begin
      case (req_i.addr)
        `DLC_LIMIT_OFF: s_nxt.rdata = s_r.lim;
        `DLC_CTRL_OFF: s_nxt.rdata = s_r.ctl;
        `DLC_STATUS_OFF: s_nxt.rdata = {4'h0, s_r.off, aux_level_status, comm_level_status};
        default: s_nxt.rdata = 8'h00;
      endcase
    end
  end

  // State register.
  // Reset loads constants only, so the asynchronous branch cannot glitch on data.
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_r <= '0;
      s_r.lim <= `DLC_LIMIT_RST;
      s_r.ctl <= `DLC_CTRL_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs steered by the registers and the fault state.
  assign rdata_o = s_r.rdata;
  assign limit_level_sel_o = s_r.lim[`DLC_LIM_LEVEL_HI:`DLC_LIM_LEVEL_LO];
  assign limit_active_o = ~s_r.lim[`DLC_LIM_OFF_BIT];
  assign comm_drive_level_o = s_r.ctl[`DLC_CTL_COMM_Q];
  assign aux_drive_level_o = s_r.ctl[`DLC_CTL_AUX_Q];
  // A driver switched off by a fault keeps its level bit; only its enable drops.
  assign comm_drive_en_o = ~s_r.off[0];
  assign aux_drive_en_o = ~s_r.off[1];
  assign low_regulator_off_o = s_r.ctl[`DLC_CTL_REG_OFF];
  assign wakeup_detect_off_o = s_r.ctl[`DLC_CTL_WAKE_OFF];
  // Only the enable is passed on; the auxiliary filter itself sits in the analog front end.
  assign aux_glitch_filter_en_o = s_r.ctl[`DLC_CTL_AUX_FILT];
  assign receive_out_o = s_r.cfilt;
  assign receive_out_oe_o = ~s_r.ctl[`DLC_CTL_RX_OFF];
  assign aux_logic_out_o = aux_level_status;

  // Checks of the register effects and the fault timing.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  lim_level_a: assert property (req_i.wr && req_i.addr == 8'h05 |=>
                                limit_level_sel_o == $past(req_i.wdata[7:6]))
    else $error("Limit level outputs do not follow the limit register.");
  limit_off_a: assert property (req_i.wr && req_i.addr == 8'h05 |=> limit_active_o == !$past(req_i.wdata[5]))
    else $error("Limit disable write did not take effect.");
  off_load_a: assert property (s_r.flt_s2[0] && !s_r.off[0] |=> s_r.ocnt[0] ==
                               ($past(s_r.lim[2:1]) == 2'h3 ? 10'd500 : 10'd50 << $past(s_r.lim[2:1])))
    else $error("Off-time counter not loaded with the selected time.");
  trip_a: assert property ($rose(s_r.flt_s2[1]) && !s_r.off[1] |=> !aux_drive_en_o)
    else $error("Auxiliary driver not switched off by a fault.");
  retry_a: assert property (s_r.off[0] && s_r.lim[0] && s_r.tick_p && s_r.ocnt[0] == 10'h000
                            && !s_r.flt_s2[0] |=> comm_drive_en_o)
    else $error("Driver not re-enabled after the off-time.");
  hold_a: assert property (s_r.off[0] && !s_r.lim[0] && !sw_write |=> !comm_drive_en_o)
    else $error("Faulted driver recovered without software.");
  reg_off_a: assert property (req_i.wr && req_i.addr == 8'h06 |=>
                              low_regulator_off_o == $past(req_i.wdata[7])
                              && wakeup_detect_off_o == $past(req_i.wdata[6]))
    else $error("Regulator or wake-up control does not follow the write.");
  aux_off_a: assert property (s_r.ctl[5] |-> !aux_logic_out_o ##1 (!$past(req_i.rd)
                              || $past(req_i.addr) != 8'h02 || !rdata_o[1]))
    else $error("Auxiliary receiver still reports while disabled.");
  rx_off_a: assert property (s_r.ctl[3] |-> !receive_out_oe_o && !comm_level_status)
    else $error("Receive output still driven while disabled.");
  filter_a: assert property (s_r.ctl[2] && s_r.line_s2[0] != s_r.cfilt && s_r.fcnt < 5'd19
                             |=> receive_out_o == $past(receive_out_o))
    else $error("Glitch shorter than the filter time passed through.");
  drive_a: assert property (req_i.wr && req_i.addr == 8'h06 |=>
                            comm_drive_level_o == $past(req_i.wdata[0])
                            && aux_drive_level_o == $past(req_i.wdata[1]))
    else $error("Driver levels do not follow the control register.");

  // Checks of the off-time hold, the software clear and the receive path.
  tar_hold_a: assert property (s_r.off[1] && s_r.lim[0] && s_r.ocnt[1] != 10'h000 |=> !aux_drive_en_o)
    else $error("Driver re-enabled before its off-time ran out.");
  clear_a: assert property (s_r.off[1] && !s_r.lim[0] && sw_write && !s_r.flt_s2[1] |=> aux_drive_en_o)
    else $error("Driver not re-enabled by a software write.");
  rx_oe_a: assert property (req_i.wr && req_i.addr == 8'h06 |=>
                            receive_out_oe_o == !$past(req_i.wdata[3]))
    else $error("Receive output enable does not follow the write.");
  filt_pass_a: assert property (!s_r.ctl[2] |=> receive_out_o == $past(s_r.line_s2[0]))
    else $error("Receive output does not follow the line with the filter off.");

  // Cover points for the main scenarios.
  trip_c: cover property ($rose(s_r.off[0]));
  hold_c: cover property (s_r.off[1] && !s_r.lim[0] && sw_write);
  retry_c: cover property (s_r.off[0] ##1 !s_r.off[0] && s_r.lim[0]);
  filt_c: cover property (s_r.ctl[2] && s_r.fcnt == 5'd19);
  rx_off_c: cover property ($rose(s_r.ctl[3]));

endmodule

//--- tb/dlc_host_model.sv
/*
  Behavioural model of the controlling microcontroller: it issues one-cycle
  register accesses on the request struct. Assumes the caller enters acc just
  after a rising clock edge; the optional gap makes the host slow or prompt.
*/
`timescale 1ns/1ps
module dlc_host_model
  import dlc_pkg::*;
(
  input wire logic clk_i,
  output dlc_req_t req_o
);
  initial req_o = '0;

  // One access, taken at the next edge, then idle cycles before the next one.
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, input int gap);
    req_o <= '{wr: w, rd: ~w, addr: a, wdata: d};
    @(posedge clk_i);
    req_o <= '0;
    repeat (gap + 1) @(posedge clk_i);
  endtask
endmodule

//--- tb/driver_limit_and_control_regs_test.sv
/*
  Self-checking bench of the driver limit and control register bank.
  Assumes the host model drives the request port; faults and lines come from here.
*/
`timescale 1ns/1ps
module driver_limit_and_control_regs_test;
  import dlc_pkg::*;
  localparam int TK = 4;
  logic clk_i = 0, rst_i = 1, comm_line_i, aux_line_i, rd_d = 0;
  logic [1:0] flt, lvl, en;
  dlc_req_t req;
  logic [7:0] rdata_o, l, c, exp_q[$];
  logic act, dl_c, dl_a, reg_off, wk_off, afilt, rx, rx_oe, aux_out;
  int bad_count = 0, compares = 0, seed = 32'h3b52, i;
  wire [10:0] pinv = {en, lvl, act, reg_off, wk_off, afilt, rx_oe, dl_a, dl_c};

  always #25 clk_i = ~clk_i;

  dlc_host_model i_host (.clk_i(clk_i), .req_o(req));
  dlc_core #(.TICK_CYCLES(TK)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .rdata_o(rdata_o),
    .comm_fault_i(flt[0]), .aux_fault_i(flt[1]), .comm_line_i(comm_line_i), .aux_line_i(aux_line_i),
    .limit_level_sel_o(lvl), .limit_active_o(act), .comm_drive_level_o(dl_c), .comm_drive_en_o(en[0]),
    .aux_drive_level_o(dl_a), .aux_drive_en_o(en[1]), .low_regulator_off_o(reg_off),
    .wakeup_detect_off_o(wk_off), .aux_glitch_filter_en_o(afilt), .receive_out_o(rx),
    .receive_out_oe_o(rx_oe), .aux_logic_out_o(aux_out));

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    if (bad_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host.acc(1'b1, a, d, {$random(seed)} % 3);
  endtask

  // The expected read value is noted first; the watcher below compares it.
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    i_host.acc(1'b0, a, 8'h00, {$random(seed)} % 3);
  endtask

  // Outputs are sampled on the falling edge so register updates have landed.
  task automatic pins(input logic [7:0] lv, input logic [7:0] cv);
    @(negedge clk_i);
    chk({1'b0, pinv}, {3'b011, lv[7:6], ~lv[5], cv[7], cv[6], cv[4], ~cv[3], cv[1], cv[0]});
    @(posedge clk_i);
  endtask

  // A low pulse of len+1 cycles on the line; e is the receive level expected at its end.
  task automatic glitch(input logic [7:0] cv, input int len, input logic e);
    wr(8'h06, cv);
    comm_line_i <= 1'b0;
    settle(len);
    @(negedge clk_i);
    chk({11'h0, rx}, {11'h0, e});
    @(posedge clk_i);
    comm_line_i <= 1'b1;
    settle(30);
  endtask

  task automatic retry(input int ch, input logic [1:0] code, input logic auto);
    int n, k;
    n = (code == 2'b00) ? 50 : (code == 2'b01) ? 100 : (code == 2'b10) ? 200 : 500;
    wr(8'h05, {5'b00000, code, auto});
    flt[ch] <= 1'b1;
    k = 0;
    do begin @(negedge clk_i); k++; end while (en[ch] !== 1'b0 && k < 10);
    chk(12'(k), 12'd4);
    @(posedge clk_i);
    flt[ch] <= 1'b0;
    if (auto) begin
      k = 0;
      do begin @(negedge clk_i); k++; end while (en[ch] !== 1'b1 && k < 3000);
      chk({11'h0, k >= n * TK - 2 && k <= (n + 1) * TK + 2}, 12'h1);
      @(posedge clk_i);
    end else begin
      settle((n + 2) * TK);
      @(negedge clk_i);
      chk({11'h0, en[ch]}, 12'h0);
      @(posedge clk_i);
      rd(8'h02, 8'h03 | (8'h04 << ch));
      wr(8'h06, 8'h00);
      pins(8'h00, 8'h00);
    end
  endtask

  // Each read result shows the cycle after the access was taken.
  always @(posedge clk_i) begin
    if (rd_d) chk({4'h0, rdata_o}, {4'h0, exp_q.pop_front()});
    rd_d <= req.rd;
  end

  initial begin
    flt = 2'b00;
    comm_line_i = 1'b1;
    aux_line_i = 1'b1;
    settle(8);
    rst_i <= 1'b0;
    @(posedge clk_i);
    pins(8'h00, 8'h00);
    rd(8'h05, 8'h00);
    rd(8'h06, 8'h00);
    rd(8'h10, 8'h00);
    repeat (4) begin
      l = 8'($random(seed));
      c = 8'($random(seed));
      wr(8'h05, l);
      wr(8'h06, c);
      wr(8'h10, ~l);
      pins(l, c);
      rd(8'h05, l);
      rd(8'h06, c);
    end
    // A reset in mid-run must bring both registers and all outputs back to their reset state.
    rst_i <= 1'b1;
    settle(2);
    rst_i <= 1'b0;
    @(posedge clk_i);
    pins(8'h00, 8'h00);
    rd(8'h05, 8'h00);
    wr(8'h06, 8'h20);
    settle(4);
    rd(8'h02, 8'h01);
    @(negedge clk_i);
    chk({11'h0, aux_out}, 12'h0);
    @(posedge clk_i);
    wr(8'h06, 8'h08);
    settle(4);
    rd(8'h02, 8'h02);
    @(negedge clk_i);
    chk({10'h0, aux_out, rx_oe}, 12'h2);
    @(posedge clk_i);
    glitch(8'h00, 8, 1'b0);
    glitch(8'h04, 8, 1'b1);
    glitch(8'h04, 25, 1'b0);
    for (i = 0; i < 4; i++) retry(i % 2, i[1:0], 1'b1);
    retry(1, 2'b00, 1'b0);
    retry(0, 2'b00, 1'b0);
    settle(3);
    wrap_up();
  end

  // A hang past about five times the expected run length ends the run as a failure.
  initial begin
    settle(20000);
    bad_count++;
    wrap_up();
  end
endmodule
